// file: regdac_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts for the regulator/DAC control.
// Assumes: Included by bare name from every design file that needs it.
// Notes: Control-port register selects are plain numbers on a select bus, not byte addresses.
//
// Function
// RL1 - LDO3 on needs power bit and master enable; with I/O supply off the code turns it on without the bit
// RL2 - Mode from mode bit or second clock pin
// RL3 - Power, source, mode bits writable, reset one
// RL4 - I/O supply off forces LDO3 normal mode
// RL5 - Oscillator supply follows clock pin and master
// RL6 - Amp DAC powers up on prepare and active
// RL7 - Prepare without active: buffer off, outputs grounded
// RL8 - Band selects pick exactly one driven output
// RL9 - Both band selects high: buffer off, grounded
// RL10 - Amp code is 8 bits, resets to 80h
// RL11 - Amp code kept across DAC power-down
// RL12 - Chip reset or master low restores amp code
// RL13 - Host powers DAC down before changing band
// RL14 - Amp power and routing ignore register contents
// RL15 - Trim DAC needs clock pin, bit, master
// RL16 - Trim power bit writable, resets high
// RL17 - Trim code 12 bits in two parts, 800h
// RL18 - Control port: high part then low part
// RL19 - Timing port loads whole trim code once
// RL20 - Trim code kept across trim DAC re-enable
// RL21 - Chip reset or master low restores trim code
// RL22 - Disabled trim DAC output pulled to ground
// RL23 - No prepare or master: outputs high impedance
`ifndef REGDAC_DEFINES_SVH
`define REGDAC_DEFINES_SVH

// Pin synchroniser depth
`define RDC_SYNC_STAGES 3

// Control-port register selects
`define RDC_SEL_W 2
`define RDC_SEL_CTRL 2'h0
`define RDC_SEL_AMP_CODE 2'h1
`define RDC_SEL_TRIM_HIGH 2'h2
`define RDC_SEL_TRIM_LOW 2'h3

// Control register field positions
`define RDC_CTRL_LDO3_POWER 0
`define RDC_CTRL_MODE_SOURCE 1
`define RDC_CTRL_LDO3_MODE 2
`define RDC_CTRL_TRIM_POWER 3

// Code widths and split of the trim code
`define RDC_AMP_CODE_W 8
`define RDC_TRIM_CODE_W 12
`define RDC_TRIM_HIGH_MSB 11
`define RDC_TRIM_HIGH_LSB 4
`define RDC_TRIM_LOW_MSB 3

// Reset values
`define RDC_CTRL_RST 4'hf
`define RDC_AMP_CODE_RST 8'h80
`define RDC_TRIM_CODE_RST 12'h800

`endif

// file: regdac_pkg.sv
// Purpose: Types shared by the regulator/DAC control modules.
// Assumes: Nothing beyond the defines header.
// Notes: Used only by scoped name.
package regdac_pkg;

    // How the three amplifier reference pins stand
    typedef enum logic [1:0] {
        AMP_HIZ,
        AMP_GROUNDED,
        AMP_DRIVEN
    } amp_pin_state_t;

    // Two-step trim update over the control port
    typedef enum logic {
        TRIM_IDLE,
        TRIM_ARMED
    } trim_seq_t;

endpackage : regdac_pkg

// file: amp_route_if.sv
// Purpose: Carries synchronised pins to the amplifier reference router and its decisions back.
// Assumes: Both ends on sys_clk.
// Notes: Decision signals are registered in the router.
`timescale 1ns/1ns
interface amp_route_if;
    logic master_en;
    logic prepare;
    logic active;
    logic sel_low;
    logic sel_high;
    logic core_on;
    logic power_up;
    logic buf_on;
    logic [2:0] drive;
    logic [2:0] ground;
    regdac_pkg::amp_pin_state_t pin_state;

    modport ctl (
        output master_en, prepare, active, sel_low, sel_high,
        input core_on, power_up, buf_on, drive, ground, pin_state
    );
    modport route (
        input master_en, prepare, active, sel_low, sel_high,
        output core_on, power_up, buf_on, drive, ground, pin_state
    );
endinterface : amp_route_if

// file: pin_sync.sv
// Purpose: Brings asynchronous pins onto sys_clk.
// Assumes: Each bit independent; no bus coherency across bits.
// Notes: A change is taken once stages one and two agree, so a one-cycle glitch is dropped.
`timescale 1ns/1ns
`include "regdac_defines.svh"
module pin_sync #(
    parameter int WIDTH = 9,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Pins
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out
);

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            logic [`RDC_SYNC_STAGES-1:0] stage_r;
            logic out_r;

            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    stage_r <= {`RDC_SYNC_STAGES{RST_VAL[gi]}};
                end else begin
                    stage_r <= {stage_r[`RDC_SYNC_STAGES-2:0], pin_in[gi]};
                end
            end

            // Stage zero is read only by stage one
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    out_r <= RST_VAL[gi];
                end else if (stage_r[1] == stage_r[2]) begin
                    out_r <= stage_r[2];
                end
            end

            assign pin_out[gi] = out_r;
        end
    endgenerate

endmodule : pin_sync

// file: amp_ref_router.sv
// Purpose: Power and output routing of the amplifier reference DAC.
// Assumes: Pins already synchronised.
// Notes: Depends on pins only; no register reaches this module.
`timescale 1ns/1ns
module amp_ref_router (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Pins in, decisions out
    amp_route_if.route rif
);

    ////////////////////////////////////////////////////////////////////////////
    // Registered decisions

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rif.core_on <= 1'b0;
            rif.power_up <= 1'b0;
            rif.buf_on <= 1'b0;
            rif.drive <= 3'h0;
            rif.ground <= 3'h0;
            rif.pin_state <= regdac_pkg::AMP_HIZ;
        end else if (!rif.master_en || !rif.prepare) begin
            rif.core_on <= 1'b0;
            rif.power_up <= 1'b0;
            rif.buf_on <= 1'b0; // RL23
            rif.drive <= 3'h0;
            rif.ground <= 3'h0; // RL23
            rif.pin_state <= regdac_pkg::AMP_HIZ;
        end else if (!rif.active || (rif.sel_low && rif.sel_high)) begin
            // Converter keeps running so the level is ready when the buffer opens
            rif.core_on <= 1'b1; // RL7 RL9
            rif.power_up <= rif.active; // RL6 RL14
            rif.buf_on <= 1'b0; // RL7 RL9
            rif.drive <= 3'h0;
            rif.ground <= 3'h7; // RL7 RL9
            rif.pin_state <= regdac_pkg::AMP_GROUNDED;
        end else begin
            rif.core_on <= 1'b1;
            rif.power_up <= 1'b1; // RL6
            rif.buf_on <= 1'b1;
            // Switching band while driven glitches the old pin; host must power down first
            rif.drive <= {rif.sel_high, rif.sel_low, !rif.sel_low && !rif.sel_high}; // RL8 RL14 RL13
            rif.ground <= {!rif.sel_high, !rif.sel_low, rif.sel_low || rif.sel_high}; // RL8
            rif.pin_state <= regdac_pkg::AMP_DRIVEN;
        end
    end

endmodule : amp_ref_router

// file: regulator_dac_control.sv
// Purpose: Control of LDO3, oscillator supply, amplifier reference DAC and frequency-trim DAC.
// Assumes: Serial framing is decoded upstream; ports here carry one-cycle write strobes on sys_clk.
// Notes: Pins pass a three-stage synchroniser, so pin effects lag by about five cycles.
`timescale 1ns/1ns
`include "regdac_defines.svh"
module regulator_dac_control (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,

    // Asynchronous control pins
    input wire logic master_reg_en,
    input wire logic chip_reset_n,
    input wire logic io_supply_indicator,
    input wire logic clock_enable_pin,
    input wire logic second_clock_enable_pin,
    input wire logic transmit_prepare_pin,
    input wire logic transmit_active_pin,
    input wire logic band_select_low,
    input wire logic band_select_high,

    // Control serial port writes
    input wire logic cp_wr_en,
    input wire logic [`RDC_SEL_W-1:0] cp_wr_sel,
    input wire logic [7:0] cp_wr_data,

    // Timing serial port writes
    input wire logic tp_wr_en,
    input wire logic [`RDC_TRIM_CODE_W-1:0] tp_wr_data,

    // Third regulator
    output logic third_regulator_output,
    output logic ldo3_normal_mode,

    // Oscillator supply
    output logic oscillator_supply_regulator,

    // Amplifier reference DAC
    output logic amp_dac_core_on,
    output logic amp_dac_power_up,
    output logic amp_buf_on,
    output logic amp_ref_output_one,
    output logic amp_ref_output_two,
    output logic amp_ref_output_three,
    output logic [2:0] amp_ref_ground,
    output logic [`RDC_AMP_CODE_W-1:0] amp_reference_code,

    // Frequency-trim DAC
    output logic frequency_trim_dac,
    output logic trim_ground,
    output logic [`RDC_TRIM_CODE_W-1:0] trim_code,
    output logic trim_armed,

    // Register state
    output logic ldo3_power_on_bit,
    output logic mode_source_select,
    output logic ldo3_mode_bit,
    output logic trim_dac_power_bit
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation

    localparam int PIN_W = 9;

    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_s;
    logic master_s;
    logic chip_rst_n_s;
    logic io_s;
    logic clk_en_s;
    logic clk_en2_s;
    logic prep_s;
    logic active_s;
    logic sel_low_s;
    logic sel_high_s;

    assign pin_raw = {band_select_high, band_select_low, transmit_active_pin,
                      transmit_prepare_pin, second_clock_enable_pin, clock_enable_pin,
                      io_supply_indicator, chip_reset_n, master_reg_en};

    // Reset to master low and chip reset asserted
    pin_sync #(
        .WIDTH(PIN_W),
        .RST_VAL(9'h000)
    ) u_pin_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pin_in(pin_raw),
        .pin_out(pin_s)
    );

    assign master_s = pin_s[0];
    assign chip_rst_n_s = pin_s[1];
    assign io_s = pin_s[2];
    assign clk_en_s = pin_s[3];
    assign clk_en2_s = pin_s[4];
    assign prep_s = pin_s[5];
    assign active_s = pin_s[6];
    assign sel_low_s = pin_s[7];
    assign sel_high_s = pin_s[8];

    // Codes return to default while either reset source is low
    logic code_clear;
    assign code_clear = !chip_rst_n_s || !master_s;

    ////////////////////////////////////////////////////////////////////////////
    // Write decode

    logic wr_ctrl;
    logic wr_amp;
    logic wr_high;
    logic wr_low;

    assign wr_ctrl = cp_wr_en && (cp_wr_sel == `RDC_SEL_CTRL);
    assign wr_amp = cp_wr_en && (cp_wr_sel == `RDC_SEL_AMP_CODE);
    assign wr_high = cp_wr_en && (cp_wr_sel == `RDC_SEL_TRIM_HIGH);
    assign wr_low = cp_wr_en && (cp_wr_sel == `RDC_SEL_TRIM_LOW);

    ////////////////////////////////////////////////////////////////////////////
    // Control bits

    logic [3:0] ctrl_r;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= `RDC_CTRL_RST; // RL3 RL16
        end else if (!chip_rst_n_s) begin
            ctrl_r <= `RDC_CTRL_RST; // RL3 RL16
        end else if (wr_ctrl) begin
            ctrl_r <= cp_wr_data[3:0]; // RL3 RL16
        end
    end

    logic pwr_bit;
    logic src_bit;
    logic mode_bit;
    logic trim_bit;

    assign pwr_bit = ctrl_r[`RDC_CTRL_LDO3_POWER];
    assign src_bit = ctrl_r[`RDC_CTRL_MODE_SOURCE];
    assign mode_bit = ctrl_r[`RDC_CTRL_LDO3_MODE];
    assign trim_bit = ctrl_r[`RDC_CTRL_TRIM_POWER];

    assign ldo3_power_on_bit = ctrl_r[`RDC_CTRL_LDO3_POWER];
    assign mode_source_select = ctrl_r[`RDC_CTRL_MODE_SOURCE];
    assign ldo3_mode_bit = ctrl_r[`RDC_CTRL_LDO3_MODE];
    assign trim_dac_power_bit = ctrl_r[`RDC_CTRL_TRIM_POWER];

    ////////////////////////////////////////////////////////////////////////////
    // Third regulator

    logic ldo3_on_r;
    logic ldo3_norm_r;

    // Without the I/O supply the bits are not trusted; run on in normal mode
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ldo3_on_r <= 1'b0;
            ldo3_norm_r <= 1'b0;
        end else if (!master_s) begin
            ldo3_on_r <= 1'b0; // RL1
            ldo3_norm_r <= 1'b0;
        end else if (!io_s) begin
            ldo3_on_r <= 1'b1; // RL4
            ldo3_norm_r <= 1'b1; // RL4
        end else begin
            ldo3_on_r <= pwr_bit; // RL1
            ldo3_norm_r <= pwr_bit && (src_bit ? mode_bit : clk_en2_s); // RL2
        end
    end

    assign third_regulator_output = ldo3_on_r;
    assign ldo3_normal_mode = ldo3_norm_r;

    ////////////////////////////////////////////////////////////////////////////
    // Oscillator supply

    logic osc_r;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_r <= 1'b0;
        end else begin
            osc_r <= clk_en_s && master_s; // RL5
        end
    end

    assign oscillator_supply_regulator = osc_r;

    ////////////////////////////////////////////////////////////////////////////
    // Amplifier reference DAC

    amp_route_if arif ();

    assign arif.master_en = master_s;
    assign arif.prepare = prep_s;
    assign arif.active = active_s;
    assign arif.sel_low = sel_low_s;
    assign arif.sel_high = sel_high_s;

    amp_ref_router u_amp_ref_router (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .rif(arif.route)
    );

    assign amp_dac_core_on = arif.core_on;
    assign amp_dac_power_up = arif.power_up;
    assign amp_buf_on = arif.buf_on;
    assign amp_ref_output_one = arif.drive[0];
    assign amp_ref_output_two = arif.drive[1];
    assign amp_ref_output_three = arif.drive[2];
    assign amp_ref_ground = arif.ground;

    logic [`RDC_AMP_CODE_W-1:0] amp_code_r;

    // Code is not touched by power state, so a power-up resumes the old level
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            amp_code_r <= `RDC_AMP_CODE_RST; // RL10
        end else if (code_clear) begin
            amp_code_r <= `RDC_AMP_CODE_RST; // RL12
        end else if (wr_amp) begin
            amp_code_r <= cp_wr_data[`RDC_AMP_CODE_W-1:0]; // RL10 RL11
        end
    end

    assign amp_reference_code = amp_code_r;

    ////////////////////////////////////////////////////////////////////////////
    // Frequency-trim two-step sequence

    regdac_pkg::trim_seq_t seq_r;
    regdac_pkg::trim_seq_t seq_nxt;
    logic commit_low;

    always_comb begin
        seq_nxt = seq_r;
        commit_low = 1'b0;
        unique case (seq_r)
            regdac_pkg::TRIM_IDLE: begin
                if (wr_high) begin
                    seq_nxt = regdac_pkg::TRIM_ARMED; // RL18
                end
            end
            regdac_pkg::TRIM_ARMED: begin
                if (wr_low) begin
                    commit_low = 1'b1; // RL18
                    seq_nxt = regdac_pkg::TRIM_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            seq_r <= regdac_pkg::TRIM_IDLE;
        end else if (code_clear) begin
            seq_r <= regdac_pkg::TRIM_IDLE; // RL21
        end else begin
            seq_r <= seq_nxt;
        end
    end

    assign trim_armed = (seq_r == regdac_pkg::TRIM_ARMED);

    ////////////////////////////////////////////////////////////////////////////
    // Frequency-trim code

    localparam int HIGH_W = `RDC_TRIM_HIGH_MSB - `RDC_TRIM_HIGH_LSB + 1;

    logic [HIGH_W-1:0] high_stage_r;
    logic [`RDC_TRIM_CODE_W-1:0] trim_code_r;

    // Staged high part is invisible at the output until its low part lands
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            high_stage_r <= HIGH_W'(`RDC_TRIM_CODE_RST >> `RDC_TRIM_HIGH_LSB); // RL17
        end else if (code_clear) begin
            high_stage_r <= HIGH_W'(`RDC_TRIM_CODE_RST >> `RDC_TRIM_HIGH_LSB); // RL21
        end else if (wr_high) begin
            high_stage_r <= cp_wr_data[HIGH_W-1:0]; // RL18
        end
    end

    // Timing port wins a same-cycle clash; it carries the fresher whole code
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            trim_code_r <= `RDC_TRIM_CODE_RST; // RL17
        end else if (code_clear) begin
            trim_code_r <= `RDC_TRIM_CODE_RST; // RL21
        end else if (tp_wr_en) begin
            trim_code_r <= tp_wr_data; // RL19
        end else if (commit_low) begin
            trim_code_r <= {high_stage_r, cp_wr_data[`RDC_TRIM_LOW_MSB:0]}; // RL17 RL18 RL20
        end
    end

    assign trim_code = trim_code_r;

    ////////////////////////////////////////////////////////////////////////////
    // Frequency-trim enable

    logic trim_en_r;
    logic trim_gnd_r;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            trim_en_r <= 1'b0;
            trim_gnd_r <= 1'b1;
        end else begin
            trim_en_r <= clk_en_s && trim_bit && master_s; // RL15
            trim_gnd_r <= !(clk_en_s && trim_bit && master_s); // RL22
        end
    end

    assign frequency_trim_dac = trim_en_r;
    assign trim_ground = trim_gnd_r;

endmodule : regulator_dac_control

// file: regulator_dac_control_assertions.sv
// Purpose: Port checks for the regulator and DAC control block.
// Assumes: No writes while the codes are held cleared.
// Notes: All outputs are registered, so relations hold in one cycle.
`timescale 1ns/1ns
`include "regdac_defines.svh"
module regulator_dac_control_assertions (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Inputs
    input wire logic io_supply_indicator,
    input wire logic cp_wr_en,
    input wire logic [`RDC_SEL_W-1:0] cp_wr_sel,
    input wire logic [7:0] cp_wr_data,
    input wire logic tp_wr_en,
    input wire logic [`RDC_TRIM_CODE_W-1:0] tp_wr_data,
    // Outputs
    input wire logic third_regulator_output,
    input wire logic ldo3_normal_mode,
    input wire logic ldo3_power_on_bit,
    input wire logic amp_dac_core_on,
    input wire logic amp_dac_power_up,
    input wire logic amp_buf_on,
    input wire logic amp_ref_output_one,
    input wire logic amp_ref_output_two,
    input wire logic amp_ref_output_three,
    input wire logic [2:0] amp_ref_ground,
    input wire logic [`RDC_AMP_CODE_W-1:0] amp_reference_code,
    input wire logic frequency_trim_dac,
    input wire logic trim_ground,
    input wire logic [`RDC_TRIM_CODE_W-1:0] trim_code,
    input wire logic trim_armed,
    input wire logic trim_dac_power_bit
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire logic [2:0] ref_drive = {amp_ref_output_three, amp_ref_output_two, amp_ref_output_one};
    ////////////////////////////////////////////////////////////////
    sequence s_stage;
        cp_wr_en && cp_wr_sel == `RDC_SEL_TRIM_HIGH && !tp_wr_en;
    endsequence
    sequence s_commit;
        cp_wr_en && cp_wr_sel == `RDC_SEL_TRIM_LOW && !tp_wr_en;
    endsequence
    a_trim_two_step: assert property (s_stage ##2 s_commit |=>
        trim_code == {$past(cp_wr_data, 3), $past(cp_wr_data[3:0])} && !trim_armed)
        else $error("trim commit wrong");
    a_low_needs_stage: assert property (s_commit ##0 !trim_armed |=> $stable(trim_code))
        else $error("unstaged low commit");
    a_timing_load: assert property (tp_wr_en |=> trim_code == $past(tp_wr_data))
        else $error("timing load lost");
    a_amp_write: assert property ((cp_wr_en && cp_wr_sel == `RDC_SEL_AMP_CODE)
        |=> amp_reference_code == $past(cp_wr_data)) else $error("amp write lost");
    a_drive_one_hot: assert property ($onehot0(ref_drive) && (ref_drive & amp_ref_ground) == 3'h0)
        else $error("outputs overlap");
    a_drive_needs_buf: assert property (|ref_drive |-> amp_buf_on && amp_dac_power_up && amp_dac_core_on)
        else $error("drive unpowered");
    a_buf_off_ground: assert property (amp_dac_core_on && !amp_buf_on |-> amp_ref_ground == 3'h7)
        else $error("outputs not grounded");
    a_ldo3_bit_off: assert property ($fell(ldo3_power_on_bit) && io_supply_indicator
        |-> ##[0:2] !third_regulator_output) else $error("third regulator stayed on");
    a_ldo3_mode_off: assert property (!third_regulator_output |-> !ldo3_normal_mode)
        else $error("mode while off");
    a_trim_off_ground: assert property ($fell(trim_dac_power_bit)
        |-> ##[0:2] (!frequency_trim_dac && trim_ground)) else $error("trim output not grounded");
endmodule : regulator_dac_control_assertions

// file: baseband_host.sv
// Purpose: Host model driving the control pins and both serial write ports.
// Assumes: Every change is made just after a rising edge.
// Notes: Pins are {master, chip reset n, io, clock, clock2, prepare, active, band low, band high}.
`timescale 1ns/1ns
`include "regdac_defines.svh"
module baseband_host (
    // Clock
    input wire logic sys_clk,
    // Control pins
    output logic [8:0] pins,
    // Control port
    output logic cp_wr_en,
    output logic [`RDC_SEL_W-1:0] cp_wr_sel,
    output logic [7:0] cp_wr_data,
    // Timing port
    output logic tp_wr_en,
    output logic [`RDC_TRIM_CODE_W-1:0] tp_wr_data
);
    initial begin
        pins = 9'h1c0;
        cp_wr_en = 1'b0;
        cp_wr_sel = '0;
        cp_wr_data = 8'h00;
        tp_wr_en = 1'b0;
        tp_wr_data = 12'h000;
    end
    ////////////////////////////////////////////////////////////////
    // Pins take five edges to cross; allow eight
    task automatic set_pins(input logic [8:0] v);
        @(posedge sys_clk);
        pins <= v;
        repeat (8) @(posedge sys_clk);
    endtask : set_pins
    // Inverted data on release exposes stale sampling
    task automatic cp_write(input logic [`RDC_SEL_W-1:0] sel, input logic [7:0] d);
        @(posedge sys_clk);
        cp_wr_en <= 1'b1;
        cp_wr_sel <= sel;
        cp_wr_data <= d;
        @(posedge sys_clk);
        cp_wr_en <= 1'b0;
        cp_wr_data <= ~d;
    endtask : cp_write
    task automatic tp_write(input logic [11:0] d);
        @(posedge sys_clk);
        tp_wr_en <= 1'b1;
        tp_wr_data <= d;
        @(posedge sys_clk);
        tp_wr_en <= 1'b0;
        tp_wr_data <= ~d;
    endtask : tp_write
    // v is {prepare, active, band low, band high}
    task automatic amp_route(input logic [3:0] v);
        set_pins({pins[8:4], 4'h0});
        set_pins({pins[8:4], 2'b00, v[1:0]});
        set_pins({pins[8:4], v});
    endtask : amp_route
endmodule : baseband_host

// file: test_regulator_dac_control.sv
// Purpose: Self-checking bench for the regulator and DAC control block.
// Assumes: Host model drives every input except clock and reset.
// Notes: A bench model tracks registers and codes and predicts every output.
`timescale 1ns/1ns
`include "regdac_defines.svh"
module test_regulator_dac_control;
    logic sys_clk, rst_n, cp_wr_en, tp_wr_en;
    logic [8:0] pins;
    logic [1:0] cp_wr_sel;
    logic [7:0] cp_wr_data, amp_reference_code;
    logic [11:0] tp_wr_data, trim_code;
    logic third_regulator_output, ldo3_normal_mode, oscillator_supply_regulator, trim_armed;
    logic amp_dac_core_on, amp_dac_power_up, amp_buf_on, amp_ref_output_one, amp_ref_output_two;
    logic amp_ref_output_three, frequency_trim_dac, trim_ground;
    logic [2:0] amp_ref_ground;
    logic ldo3_power_on_bit, mode_source_select, ldo3_mode_bit, trim_dac_power_bit;
    int n_errors = 0, n_compared = 0;
    int m_ctrl = 15, m_amp = 128, m_trim = 2048, m_stage = 0, m_armed = 0;
    logic [11:0] tv;

    baseband_host i_host (.*);
    regulator_dac_control i_dut (.master_reg_en(pins[8]), .chip_reset_n(pins[7]), .io_supply_indicator(pins[6]),
        .clock_enable_pin(pins[5]), .second_clock_enable_pin(pins[4]), .transmit_prepare_pin(pins[3]),
        .transmit_active_pin(pins[2]), .band_select_low(pins[1]), .band_select_high(pins[0]), .*);

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic check_all;
        logic [8:0] p;
        logic [2:0] drv;
        logic third, tr_en, core, pu, bon;
        #1;
        p = pins;
        third = p[8] && (!p[6] || m_ctrl[0]);
        tr_en = p[8] && p[5] && m_ctrl[3];
        core = p[8] && p[3];
        pu = core && p[2];
        bon = pu && !(p[1] && p[0]);
        drv = bon ? 3'(3'b001 << {p[0], p[1]}) : 3'b000;
        chk("ldo3", third_regulator_output, third);
        chk("mode", ldo3_normal_mode, third && (!p[6] || (m_ctrl[1] ? m_ctrl[2] : p[4])));
        chk("osc", oscillator_supply_regulator, p[8] && p[5]);
        chk("trim_on", frequency_trim_dac, tr_en);
        chk("trim_gnd", trim_ground, !tr_en);
        chk("core", amp_dac_core_on, core);
        chk("power", amp_dac_power_up, pu);
        chk("buf", amp_buf_on, bon);
        chk("drive", {amp_ref_output_three, amp_ref_output_two, amp_ref_output_one}, drv);
        chk("ground", amp_ref_ground, core ? 3'(~drv) : 3'h0);
        chk("amp_code", amp_reference_code, m_amp);
        chk("trim_code", trim_code, m_trim);
        chk("armed", trim_armed, m_armed);
        chk("ctrl", {trim_dac_power_bit, ldo3_mode_bit, mode_source_select, ldo3_power_on_bit}, m_ctrl);
    endtask : check_all
    task automatic cp_wr(input logic [1:0] sel, input logic [7:0] d);
        i_host.cp_write(sel, d);
        case (sel)
            `RDC_SEL_CTRL: m_ctrl = d[3:0];
            `RDC_SEL_AMP_CODE: m_amp = d;
            `RDC_SEL_TRIM_HIGH: begin
                m_stage = d;
                m_armed = 1;
            end
            default: if (m_armed == 1) begin
                m_trim = m_stage * 16 + d[3:0];
                m_armed = 0;
            end
        endcase
    endtask : cp_wr
    task automatic trim_wr(input logic [11:0] c);
        cp_wr(`RDC_SEL_TRIM_HIGH, c[11:4]);
        cp_wr(`RDC_SEL_TRIM_LOW, {4'($urandom), c[3:0]});
    endtask : trim_wr
    task automatic pins_to(input logic [8:0] v);
        i_host.set_pins(v);
        if (!v[8] || !v[7]) begin
            m_amp = 128;
            m_trim = 2048;
            m_armed = 0;
        end
        if (!v[7]) m_ctrl = 15;
    endtask : pins_to
    task automatic tally_and_finish;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish
    ////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'hb4cb));
        rst_n = 1'b0;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge sys_clk);
        check_all;
        for (int i = 0; i < 64; i++) begin
            cp_wr(`RDC_SEL_CTRL, {4'($urandom), 4'(i)});
            pins_to({2'b11, i[4], i[5], 1'($urandom), 4'h0});
            check_all;
        end
        cp_wr(`RDC_SEL_AMP_CODE, 8'($urandom));
        for (int i = 0; i < 16; i++) begin
            // Register traffic must not disturb amp routing
            cp_wr(`RDC_SEL_CTRL, 8'($urandom));
            i_host.amp_route(4'(i));
            check_all;
        end
        cp_wr(`RDC_SEL_CTRL, 8'h0f);
        pins_to(9'h1e0);
        trim_wr(12'($urandom));
        check_all;
        cp_wr(`RDC_SEL_TRIM_LOW, 8'($urandom));
        cp_wr(`RDC_SEL_TRIM_HIGH, 8'($urandom));
        trim_wr(12'($urandom));
        check_all;
        tv = 12'($urandom);
        i_host.tp_write(tv);
        m_trim = tv;
        pins_to(9'h1c0);
        pins_to(9'h1e0);
        check_all;
        cp_wr(`RDC_SEL_CTRL, 8'h02);
        cp_wr(`RDC_SEL_AMP_CODE, 8'($urandom));
        trim_wr(12'($urandom));
        pins_to(9'h160);
        pins_to(9'h1e0);
        check_all;
        cp_wr(`RDC_SEL_AMP_CODE, 8'($urandom));
        trim_wr(12'($urandom));
        pins_to(9'h0ec);
        check_all;
        pins_to(9'h1e0);
        check_all;
        tally_and_finish;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        tally_and_finish;
    end
endmodule : test_regulator_dac_control

bind regulator_dac_control regulator_dac_control_assertions i_chk (.*);
